// ---- deac_map.svh ----
/*
 * Register offsets, control bit positions, key values, depth and timing counts
 * of the data storage access controller.
 * Assumes inclusion by the package and the design; definitions only.
 */
`ifndef DEAC_MAP_SVH
`define DEAC_MAP_SVH

// special function register addresses (12-bit space)
`define DEAC_ADDR_CTRL    12'hFA6
`define DEAC_ADDR_KEY     12'hFA7
`define DEAC_ADDR_DATA    12'hFA8
`define DEAC_ADDR_ADDR    12'hFA9

// control register bit positions
`define DEAC_BIT_SEL      7
`define DEAC_BIT_CFG      6
`define DEAC_BIT_ROW      4
`define DEAC_BIT_ERR      3
`define DEAC_BIT_PERMIT   2
`define DEAC_BIT_WGO      1
`define DEAC_BIT_RGO      0

// unlock key values
`define DEAC_KEY1         8'h55
`define DEAC_KEY2         8'hAA

// storage depth and timing
`define DEAC_DEPTH        256
`define DEAC_PWRUP_MS     72
`define DEAC_CLK_MHZ      100
`define DEAC_PWRUP_CYC    (`DEAC_PWRUP_MS * 1000 * `DEAC_CLK_MHZ)
`define DEAC_WRITE_CYC    200

`endif

// ---- deac_pkg.sv ----
/*
 * Types of the data storage access controller.
 * Assumes deac_map.svh is on the include path.
 */
package deac_pkg;
	`include "deac_map.svh"

	// unlock sequence progress
	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_GOT1,
		KEY_ARMED
	} deac_key_t;

	// external programming port request, carried through its synchroniser
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       prot;
		logic [7:0] addr;
		logic [7:0] wdata;
	} deac_ext_t;

	// cpu register access request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [11:0] addr;
		logic [7:0] wdata;
	} deac_req_t;

	// whole state of the controller
	typedef struct packed {
		logic [7:0]  addr;
		logic [7:0]  data;
		logic        sel;
		logic        cfg;
		logic        row;
		logic        err;
		logic        permit;
		logic        permit_old;
		logic        wgo;
		logic        rgo;
		logic        done_irq;
		deac_key_t   key;
		logic [31:0] wcnt;
		logic [31:0] pwcnt;
		logic        pwok;
		logic [7:0]  rdata;
		deac_ext_t   ext_s1;
		deac_ext_t   ext_s2;
		logic [7:0]  ext_rdata;
	} deac_state_t;
endpackage : deac_pkg

// ---- deac_ctrl.sv ----
/*
 * Data storage access controller: 256-byte byte-wide nonvolatile array
 * reached by the cpu only through address, data, control and unlock-key
 * registers, and directly by the external programming port.
 * Assumes a CPU register port on CLK, a power-on reset on RST_B and
 * a single warm-reset input WARM_RST sampled on the same clock.
 */
module deac_ctrl
	import deac_pkg::*;
#(
	parameter int WRITE_CYC = `DEAC_WRITE_CYC,
	parameter int PWRUP_CYC = `DEAC_PWRUP_CYC
) (
	// clock and resets
	input  wire logic        CLK,
	input  wire logic        RST_B,
	input  wire logic        WARM_RST,
	// cpu register port
	input  wire deac_req_t   CPU_REQ,
	output logic [7:0]       CPU_RDATA,
	// external programming port
	input  wire logic        EXT_PROTECT,
	input  wire logic        EXT_WR,
	input  wire logic        EXT_RD,
	input  wire logic [7:0]  EXT_ADDR,
	input  wire logic [7:0]  EXT_WDATA,
	output logic [7:0]       EXT_RDATA,
	// status
	output logic             DONE_IRQ_FLAG,
	input  wire logic        DONE_IRQ_CLR,
	output logic             WRITE_BUSY
);

	////////////////////////////////////////////////////////////////////////
	// storage array and state

	// the array itself; no reset, like the cells it stands for
	logic [7:0]  mem [0:`DEAC_DEPTH-1];

	// whole controller state and its next value
	deac_state_t st;
	deac_state_t next_st;

	// decisions taken from the current cpu request and state
	logic        key_wr;
	logic        addr_wr;
	logic        data_wr;
	logic        ctrl_wr;
	logic        data_target;
	logic        wr_go_req;
	logic        start_wr;
	logic        start_rd;
	logic        finish;
	logic        ext_ok;
	logic [7:0]  ctrl_view;

	// power-on value of the state; the external port counts as
	// protected until its synchroniser has seen the real level, so
	// that no external access can slip in during the first cycles
	localparam deac_state_t RESET_ST = '{
		key:     KEY_IDLE,
		ext_s1:  '{prot: 1'b1, default: '0},
		ext_s2:  '{prot: 1'b1, default: '0},
		default: '0
	};

	////////////////////////////////////////////////////////////////////////
	// register decode
	//
	// the array is never mapped into the cpu register space; the only
	// way in is through the address, data, control and key registers

	// cpu write strobes per register
	assign key_wr  = CPU_REQ.wr && CPU_REQ.addr == `DEAC_ADDR_KEY;
	assign addr_wr = CPU_REQ.wr && CPU_REQ.addr == `DEAC_ADDR_ADDR;
	assign data_wr = CPU_REQ.wr && CPU_REQ.addr == `DEAC_ADDR_DATA;
	assign ctrl_wr = CPU_REQ.wr && CPU_REQ.addr == `DEAC_ADDR_CTRL;

	////////////////////////////////////////////////////////////////////////
	// start decisions
	//
	// every guard on a write start is folded into one term so that a
	// refused request leaves no trace beyond the plain bit updates

	// both select bits clear point the access at the data array
	assign data_target = !CPU_REQ.wdata[`DEAC_BIT_SEL]
		&& !CPU_REQ.wdata[`DEAC_BIT_CFG];

	// a program-go request only counts while no write runs
	assign wr_go_req = ctrl_wr && CPU_REQ.wdata[`DEAC_BIT_WGO] && !st.wgo;

	// permit must already stand from an earlier instruction, the key
	// pair must be the two writes just before, and the power-up timer
	// must have run out; anything else is silently ignored
	assign start_wr  = wr_go_req && data_target
		&& st.key == KEY_ARMED
		&& st.permit_old && st.permit
		&& st.pwok;

	// a read-go request while idle fetches the addressed byte at once
	assign start_rd  = ctrl_wr && !st.wgo && data_target
		&& CPU_REQ.wdata[`DEAC_BIT_RGO];

	// last cycle of the self-timed write
	assign finish    = st.wgo && st.wcnt == 32'(WRITE_CYC - 1);

	// external access only with protection off and no cpu write running;
	// the cpu side is never refused by the protection level
	assign ext_ok    = !st.ext_s2.prot && !st.wgo;

	// control register as software sees it; bit 5 is unimplemented
	assign ctrl_view = {st.sel, st.cfg, 1'b0, st.row, st.err,
		st.permit, st.wgo, st.rgo};

	////////////////////////////////////////////////////////////////////////
	// next state
	//
	// one process computes the whole next state; the warm reset is the
	// last override so that it wins over every cpu request of its cycle
	always_comb begin
		next_st = st;
		next_st.permit_old = st.permit;

		// power-up timer: cpu writes to the array stay blocked until it runs out
		if (!st.pwok) begin
			next_st.pwcnt = st.pwcnt + 32'h1;
			if (st.pwcnt == 32'(PWRUP_CYC - 1)) begin
				next_st.pwok = 1'b1;
			end
		end

		// read-go lasts exactly one cycle
		next_st.rgo = 1'b0;

		// unlock tracker: any other write between the keys disarms it,
		// so the sequence has to come back to back
		if (key_wr) begin
			if (CPU_REQ.wdata == `DEAC_KEY1) begin
				next_st.key = KEY_GOT1;
			end else if (CPU_REQ.wdata == `DEAC_KEY2
				&& st.key == KEY_GOT1) begin
				next_st.key = KEY_ARMED;
			end else begin
				next_st.key = KEY_IDLE;
			end
		end else if (CPU_REQ.wr) begin
			next_st.key = KEY_IDLE;
		end

		// self-timed write; address, data and control writes are refused meanwhile,
		// which also means the cpu cannot cancel a running write
		if (st.wgo) begin
			next_st.wcnt = st.wcnt + 32'h1;
			if (finish) begin
				next_st.wgo      = 1'b0;
				next_st.err      = 1'b0;
				next_st.done_irq = 1'b1;
				next_st.wcnt     = 32'h0;
			end
		end else if (addr_wr) begin
			next_st.addr = CPU_REQ.wdata;
		end else if (data_wr) begin
			next_st.data = CPU_REQ.wdata;
		end else if (ctrl_wr) begin
			// plain bits follow the write; the go bits are only set here
			next_st.sel    = CPU_REQ.wdata[`DEAC_BIT_SEL];
			next_st.cfg    = CPU_REQ.wdata[`DEAC_BIT_CFG];
			next_st.row    = CPU_REQ.wdata[`DEAC_BIT_ROW];
			next_st.err    = CPU_REQ.wdata[`DEAC_BIT_ERR];
			next_st.permit = CPU_REQ.wdata[`DEAC_BIT_PERMIT];
			if (start_wr) begin
				next_st.wgo = 1'b1;
				next_st.key = KEY_IDLE;
			end
			if (start_rd) begin
				next_st.data = mem[st.addr];
				next_st.rgo  = 1'b1;
			end
		end

		// software clear of the done flag; a set in the same cycle wins
		if (DONE_IRQ_CLR && !finish) begin
			next_st.done_irq = 1'b0;
		end

		// cpu read answer, registered; it holds until the next read or a warm reset
		if (CPU_REQ.rd) begin
			if (CPU_REQ.addr == `DEAC_ADDR_ADDR) begin
				next_st.rdata = st.addr;
			end else if (CPU_REQ.addr == `DEAC_ADDR_DATA) begin
				next_st.rdata = st.data;
			end else if (CPU_REQ.addr == `DEAC_ADDR_CTRL) begin
				next_st.rdata = ctrl_view;
			end else begin
				next_st.rdata = 8'h00;
			end
		end

		// external port: two flip-flops before any logic looks at it;
		// address and data must stand still across the sampled span,
		// since the bus is not gray coded
		next_st.ext_s1 = '{wr: EXT_WR, rd: EXT_RD, prot: EXT_PROTECT,
			addr: EXT_ADDR, wdata: EXT_WDATA};
		next_st.ext_s2 = st.ext_s1;

		// external read answer; zero when refused
		if (st.ext_s2.rd && ext_ok) begin
			next_st.ext_rdata = mem[st.ext_s2.addr];
		end else begin
			next_st.ext_rdata = 8'h00;
		end

		// warm reset (master clear or watchdog): a running write is cut
		// short and flagged; select and row bits are kept for tracing
		if (WARM_RST) begin
			next_st.addr       = 8'h00;
			next_st.data       = 8'h00;
			next_st.err        = st.err | st.wgo;
			next_st.sel        = st.sel;
			next_st.cfg        = st.cfg;
			next_st.row        = st.row;
			next_st.done_irq   = st.done_irq && !DONE_IRQ_CLR;
			next_st.wgo        = 1'b0;
			next_st.rgo        = 1'b0;
			next_st.key        = KEY_IDLE;
			next_st.wcnt       = 32'h0;
			next_st.permit     = 1'b0;
			next_st.permit_old = 1'b0;
			next_st.rdata      = 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			st <= RESET_ST;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// array write port
	//
	// the cpu byte lands only at completion, so an aborted write leaves
	// the old value; the external port is refused while the cpu writes
	always_ff @(posedge CLK) begin
		if (finish && !WARM_RST) begin
			mem[st.addr] <= st.data;
		end else if (st.ext_s2.wr && ext_ok) begin
			mem[st.ext_s2.addr] <= st.ext_s2.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all straight from the state register
	assign CPU_RDATA     = st.rdata;
	assign EXT_RDATA     = st.ext_rdata;
	assign DONE_IRQ_FLAG = st.done_irq;
	assign WRITE_BUSY    = st.wgo;

endmodule : deac_ctrl

// ---- deac_ctrl_assertions.sv ----
/* port checker of the storage access controller
 bound to deac_ctrl; one clock, power-on reset RST_B */
module deac_ctrl_chk
	import deac_pkg::*;
#(parameter int WRITE_CYC = 5) (
	// clock and resets
	input wire logic      CLK,
	input wire logic      RST_B,
	input wire logic      WARM_RST,
	// cpu and external ports
	input wire deac_req_t CPU_REQ,
	input wire logic[7:0] CPU_RDATA,
	input wire logic      EXT_PROTECT,
	input wire logic      EXT_RD,
	input wire logic[7:0] EXT_RDATA,
	// status
	input wire logic      DONE_IRQ_FLAG,
	input wire logic      DONE_IRQ_CLR,
	input wire logic      WRITE_BUSY
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	int cnt;
	// key port writes and a legal program-go write
	wire kw = CPU_REQ.wr && CPU_REQ.addr == 12'hFA7;
	wire go = CPU_REQ.wr && CPU_REQ.addr == 12'hFA6
		&& CPU_REQ.wdata[2:1] == 2'h3 && CPU_REQ.wdata[7:6] == 2'h0;
	// busy cycles; a warm abort cuts the count short
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) cnt <= 0;
		else cnt <= WRITE_BUSY ? cnt + 1 : 0;
	end
	sequence s_abort;
		WRITE_BUSY && WARM_RST;
	endsequence
	sequence s_end;
		$fell(WRITE_BUSY) && !$past(WARM_RST);
	endsequence
	AST_START: assert property ($rose(WRITE_BUSY) |-> $past(go)
		&& $past(kw && CPU_REQ.wdata == 8'hAA, 2)
		&& $past(kw && CPU_REQ.wdata == 8'h55, 3)) else $error("bad start");
	AST_LEN: assert property (s_end |-> cnt == WRITE_CYC)
		else $error("write length");
	AST_DONE: assert property (s_end |-> DONE_IRQ_FLAG)
		else $error("no done flag");
	AST_DRISE: assert property ($rose(DONE_IRQ_FLAG) |-> $fell(WRITE_BUSY))
		else $error("done without end");
	AST_STICK: assert property (DONE_IRQ_FLAG && !DONE_IRQ_CLR |=>
		DONE_IRQ_FLAG) else $error("flag lost");
	AST_ABORT: assert property (s_abort |=> !WRITE_BUSY)
		else $error("abort ignored");
	AST_KEY0: assert property (CPU_REQ.rd && CPU_REQ.addr == 12'hFA7 |=>
		CPU_RDATA == 8'h00) else $error("key read");
	AST_EXT: assert property ($past(EXT_PROTECT, 3) && $past(EXT_RD, 3) |->
		EXT_RDATA == 8'h00) else $error("ext read");
endmodule : deac_ctrl_chk
////////////////////////////////
bind deac_ctrl deac_ctrl_chk #(.WRITE_CYC(WRITE_CYC)) u_chk (.CLK, .RST_B,
	.WARM_RST, .CPU_REQ, .CPU_RDATA, .EXT_PROTECT, .EXT_RD, .EXT_RDATA,
	.DONE_IRQ_FLAG, .DONE_IRQ_CLR, .WRITE_BUSY);

// ---- deac_ctrl_tb.sv ----
/* self-checking bench of the storage access controller
 drives the cpu port itself; short write and power-up counts */
module deac_ctrl_tb;
	import deac_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int WC = 5;
	logic clk = 0, rst_b = 0, warm = 0, ext_rd = 0, clr = 0, pend = 0;
	logic prot = 1;
	logic [7:0] rdata, erd, a = 0, d = 0;
	logic flag, busy;
	deac_req_t req = '0;
	logic [7:0] q[$];
	int mismatches = 0, n_checks = 0, cyc = 0;
	deac_ctrl #(.WRITE_CYC(WC), .PWRUP_CYC(10)) uut (.CLK(clk), .RST_B(rst_b),
		.WARM_RST(warm), .CPU_REQ(req), .CPU_RDATA(rdata),
		.EXT_PROTECT(prot), .EXT_WR(1'b0), .EXT_RD(ext_rd), .EXT_ADDR(a),
		.EXT_WDATA(8'h00), .EXT_RDATA(erd), .DONE_IRQ_FLAG(flag),
		.DONE_IRQ_CLR(clr), .WRITE_BUSY(busy));
	task chk(input logic [7:0] s, e);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask : chk
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : close_out
	// one register access; for reads dt is the expected answer
	task op(input logic r, input logic [11:0] ad, input logic [7:0] dt);
		@(posedge clk);
		req <= {!r, r, ad, dt};
		if (r) q.push_back(dt);
	endtask : op
	task idle(input int n);
		repeat (n) begin
			@(posedge clk);
			req <= '0;
		end
		#1;
	endtask : idle
	task unlock(input logic [7:0] c);
		op(0, 12'hFA7, 8'h55);
		op(0, 12'hFA7, 8'hAA);
		op(0, 12'hFA6, c);
	endtask : unlock
	////////////////////////////////
	// answer lands the cycle after the read is taken
	always @(posedge clk) pend <= req.rd;
	always @(negedge clk) if (pend) chk(rdata, q.pop_front());
	// hang guard
	always @(posedge clk) if (++cyc > 2000) begin
		mismatches++;
		close_out;
	end
	initial forever #5 clk = ~clk;
	initial begin
		void'($urandom(60));
		a = $urandom;
		d = $urandom;
		repeat (3) @(posedge clk);
		rst_b <= 1;
		op(0, 12'hFA6, 8'h04);
		unlock(8'h06);
		op(1, 12'hFA6, 8'h04);
		idle(12);
		op(0, 12'hFA6, 8'h00);
		unlock(8'h06);
		op(1, 12'hFA6, 8'h04);
		op(0, 12'hFA9, a);
		op(0, 12'hFA8, d);
		unlock(8'h06);
		op(0, 12'hFA8, ~d);
		op(0, 12'hFA9, ~a);
		idle(2);
		while (busy) idle(1);
		chk({7'h00, flag}, 8'h01);
		op(1, 12'hFA8, d);
		op(1, 12'hFA9, a);
		op(0, 12'hFA8, ~d);
		op(0, 12'hFA6, 8'h01);
		op(1, 12'hFA8, d);
		op(1, 12'hFA6, 8'h00);
		op(1, 12'hFA7, 8'h00);
		op(1, 12'hFA0, 8'h00);
		op(0, 12'hFA6, 8'h14);
		unlock(8'h16);
		idle(2);
		@(posedge clk);
		warm <= 1;
		ext_rd <= 1;
		@(posedge clk);
		warm <= 0;
		ext_rd <= 0;
		clr <= 1;
		op(1, 12'hFA6, 8'h18);
		op(1, 12'hFA9, 8'h00);
		op(1, 12'hFA8, 8'h00);
		clr <= 0;
		idle(2);
		chk({7'h00, flag}, 8'h00);
		// unprotected external read of the byte written above
		@(posedge clk);
		prot <= 0;
		repeat (3) @(posedge clk);
		ext_rd <= 1;
		@(posedge clk);
		ext_rd <= 0;
		repeat (2) @(posedge clk);
		#1;
		chk(erd, d);
		close_out;
	end
endmodule : deac_ctrl_tb
